//--- design/btio_top.sv
// Backplane trigger and star line controller for two protocol cores.
// Assumes one 20 MHz clock; backplane pins and the switch are asynchronous.
//
// Summary of operation
// - Protocol clock is the on-board oscillator or backplane reference.
// - Clock-select switch sampled once after reset, held until next reset.
// - Sampled source readable: 0 backplane reference, 1 on-board oscillator.
// - Every backplane input passes a two-flop synchroniser before use.
// - Eight trigger lines map to indices 33 to 40 for read, write, enable.
// - Star inputs at 41 and 42, bidirectional star 43, output star 44.
// - Twelve lines monitored in bank 2, rise and fall bit per line.
// - Bidirectional lines float after reset until software enables drivers.
// - Enable set drives written level unless a sync is mapped to the line; line floats once neither core enables it nor maps a sync to it.
// - A write clearing the enable ignores the supplied value.
// - Both cores enabling one line: most recent writer's value drives.
// - Enabled output star carries a continuous 10 MHz 50 percent wave.
// - Output star 44 is controlled only by its enable, never floats.
// - Core triggers sourced from, syncs driven onto, fixed backplane lines.
// - One source per trigger input; a sync may drive several lines.
// - Triggers qualified as high, low, rising or falling.
// - Output-enable bitmask for indices 33 to 48 is readable.
`include "btio_regs.svh"

module btio_top
  import btio_pkg::*;
(
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      reset,
  // Clock selection
  input  wire logic                      clock_select_switch,
  output logic                           clk_src_onboard,
  output logic                           clk_src_valid,
  // Discrete access, one lane per core
  input  wire logic [1:0]                dio_wr,
  input  wire logic [1:0][5:0]           dio_idx,
  input  wire logic [1:0]                dio_en,
  input  wire logic [1:0]                dio_val,
  output logic [`BTIO_NLINES-1:0]        line_state,
  output logic [`BTIO_OE_MASK_W-1:0]     out_en_mask,
  // Edge monitor
  input  wire logic [`BTIO_NLINES-1:0]   rise_en,
  input  wire logic [`BTIO_NLINES-1:0]   fall_en,
  input  wire logic [`BTIO_NLINES-1:0]   rise_clr,
  input  wire logic [`BTIO_NLINES-1:0]   fall_clr,
  output logic [`BTIO_NLINES-1:0]        rise_flag,
  output logic [`BTIO_NLINES-1:0]        fall_flag,
  output logic                           mon_event,
  // Protocol triggers and syncs
  input  wire logic [1:0][2:0]           trig_src_star,
  input  wire btio_pol_t [1:0][2:0]      trig_pol,
  output logic [1:0][2:0]                core_trig,
  input  wire logic [1:0][2:0]           core_sync,
  input  wire logic [1:0][3:0]           sync_map,
  // Backplane pins
  input  wire logic [7:0]                trig_i,
  output logic [7:0]                     trig_o,
  output logic [7:0]                     trig_oe_n,
  input  wire logic [1:0]                dstar_i,
  input  wire logic                      star_i,
  output logic                           star_o,
  output logic                           star_oe_n,
  output logic                           dstarc_o
);

  localparam int N = `BTIO_NLINES;
  localparam logic [3:0] HALF_M1 = 4'(`BTIO_REF_HALF - 1);

  // Returns {valid, line} for a discrete index.
  function automatic logic [4:0] idx_line(input logic [5:0] idx);
    logic [5:0] off;
    off = idx - `BTIO_IDX_FIRST;
    if (idx >= `BTIO_IDX_FIRST && idx <= `BTIO_IDX_LAST)
      idx_line = {1'b1, off[3:0]};
    else
      idx_line = 5'h00;
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [N-1:0] s1_reg, s2_reg, prev_reg;
  logic         sw1_reg, sw2_reg;
  logic [N-1:0] raw, cur;

  always_comb begin
    raw = {1'b0, star_i, dstar_i, trig_i};
    cur = {dstarc_o, s2_reg[N-2:0]};
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s1_reg   <= '0;
      s2_reg   <= '0;
      prev_reg <= '0;
      sw1_reg  <= 1'b0;
      sw2_reg  <= 1'b0;
    end else begin
      s1_reg   <= raw;
      s2_reg   <= s1_reg;
      prev_reg <= cur;
      sw1_reg  <= clock_select_switch;
      sw2_reg  <= sw1_reg;
    end
  end

  assign line_state = cur;

  // ----------------------------------------------------------------
  // Clock source capture
  // ----------------------------------------------------------------
  btio_cs_t cs_reg, cs_next;
  logic     src_reg, src_next;

  always_comb begin
    cs_next  = cs_reg;
    src_next = src_reg;
    case (cs_reg)
      CS_FILL0: cs_next = CS_FILL1;
      CS_FILL1: cs_next = CS_FILL2;
      CS_FILL2: begin
        src_next = sw2_reg;
        cs_next  = CS_HELD;
      end
      CS_HELD:  cs_next = CS_HELD;
      default:  cs_next = CS_FILL0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cs_reg  <= CS_FILL0;
      src_reg <= 1'b0;
    end else begin
      cs_reg  <= cs_next;
      src_reg <= src_next;
    end
  end

  assign clk_src_onboard = src_reg;
  assign clk_src_valid   = (cs_reg == CS_HELD);

  // Edge detection waits until the synchronisers hold real pin levels.
  logic mon_ok;
  assign mon_ok = (cs_reg == CS_HELD);

  // ----------------------------------------------------------------
  // Discrete writes and line drivers
  // ----------------------------------------------------------------
  logic [1:0][N-1:0] en_reg, en_next, val_reg, val_next;
  logic [N-1:0]      last_reg, last_next;
  logic [N-1:0]      drv_o_next, drv_oe_n_next;
  logic [N-1:0]      drv_o_reg, drv_oe_n_reg;
  logic [4:0]        dec;
  logic              sel;

  always_comb begin
    en_next   = en_reg;
    val_next  = val_reg;
    last_next = last_reg;
    dec       = 5'h00;
    for (int c = 0; c < 2; c++) begin
      dec = idx_line(dio_idx[c]);
      if (dio_wr[c] && dec[4]) begin
        en_next[c][dec[3:0]] = dio_en[c];
        if (dio_en[c]) begin
          val_next[c][dec[3:0]] = dio_val[c];
        end
        last_next[dec[3:0]] = 1'(c);
      end
    end
  end

  always_comb begin
    drv_o_next    = '0;
    drv_oe_n_next = '1;
    sel           = 1'b0;
    for (int l = 0; l < N; l++) begin
      sel = (en_reg[0][l] && en_reg[1][l]) ? last_reg[l] : en_reg[1][l];
      if (en_reg[0][l] || en_reg[1][l]) begin
        drv_o_next[l]    = val_reg[sel][l];
        drv_oe_n_next[l] = 1'b0;
      end
    end
    for (int s = 0; s < 4; s++) begin
      if (sync_map[0][s] || sync_map[1][s]) begin
        drv_oe_n_next[(s == 3) ? 10 : s] = 1'b0;
        drv_o_next[(s == 3) ? 10 : s] =
          sync_map[0][s] ? core_sync[0][(s == 3) ? 2 : s]
                         : core_sync[1][(s == 3) ? 2 : s];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      en_reg       <= '0;
      val_reg      <= '0;
      last_reg     <= '0;
      drv_o_reg    <= '0;
      drv_oe_n_reg <= '1;
    end else begin
      en_reg       <= en_next;
      val_reg      <= val_next;
      last_reg     <= last_next;
      drv_o_reg    <= drv_o_next;
      drv_oe_n_reg <= drv_oe_n_next;
    end
  end

  assign trig_o    = drv_o_reg[7:0];
  assign trig_oe_n = drv_oe_n_reg[7:0];
  assign star_o    = drv_o_reg[10];
  assign star_oe_n = drv_oe_n_reg[10];

  // The star output is enabled by either core's last write to index 44.
  logic ref_on;
  assign ref_on = en_reg[0][11] | en_reg[1][11];

  always_comb begin
    out_en_mask     = '0;
    out_en_mask[7:0] = ~drv_oe_n_reg[7:0];
    out_en_mask[10] = ~drv_oe_n_reg[10];
    out_en_mask[11] = ref_on;
  end

  // ----------------------------------------------------------------
  // 10 MHz reference on the output-only star line
  // ----------------------------------------------------------------
  logic [3:0] div_reg, div_next;
  logic       ref_reg, ref_next;

  always_comb begin
    div_next = div_reg;
    ref_next = ref_reg;
    if (!ref_on) begin
      div_next = '0;
      ref_next = 1'b0;
    end else if (div_reg == HALF_M1) begin
      div_next = '0;
      ref_next = ~ref_reg;
    end else begin
      div_next = div_reg + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      div_reg <= '0;
      ref_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      ref_reg <= ref_next;
    end
  end

  assign dstarc_o = ref_reg;

  // ----------------------------------------------------------------
  // Edge monitor
  // ----------------------------------------------------------------
  logic [N-1:0] rise_reg, fall_reg, rise_next, fall_next;

  always_comb begin
    rise_next = (rise_reg & ~rise_clr)
              | (cur & ~prev_reg & rise_en & {N{mon_ok}});
    fall_next = (fall_reg & ~fall_clr)
              | (~cur & prev_reg & fall_en & {N{mon_ok}});
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rise_reg <= '0;
      fall_reg <= '0;
    end else begin
      rise_reg <= rise_next;
      fall_reg <= fall_next;
    end
  end

  assign rise_flag = rise_reg;
  assign fall_flag = fall_reg;
  assign mon_event = |{rise_reg, fall_reg};

  // ----------------------------------------------------------------
  // Protocol trigger qualification
  // ----------------------------------------------------------------
  logic [1:0][2:0] trig_next, trig_reg;
  logic [3:0]      ln;

  always_comb begin
    trig_next = '0;
    ln        = '0;
    for (int c = 0; c < 2; c++) begin
      for (int t = 0; t < 3; t++) begin
        ln = trig_src_star[c][t] ? 4'(t + 8) : 4'(t);
        case (trig_pol[c][t])
          POL_HIGH: trig_next[c][t] = cur[ln];
          POL_LOW:  trig_next[c][t] = ~cur[ln];
          POL_RISE: trig_next[c][t] = cur[ln] & ~prev_reg[ln] & mon_ok;
          POL_FALL: trig_next[c][t] = ~cur[ln] & prev_reg[ln] & mon_ok;
          default:  trig_next[c][t] = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      trig_reg <= '0;
    end else begin
      trig_reg <= trig_next;
    end
  end

  assign core_trig = trig_reg;

endmodule

//--- pkg/btio_regs.svh
// Constants for the backplane trigger block: line indices, counts, timing.
// Assumes inclusion by the package and the design file by bare name.
`ifndef BTIO_REGS_SVH
`define BTIO_REGS_SVH

// ----------------------------------------------------------------
// Line indices and layout
// ----------------------------------------------------------------
`define BTIO_IDX_FIRST   6'd33
`define BTIO_IDX_LAST    6'd44
`define BTIO_NLINES      12
`define BTIO_LINE_DSTARA 4'd8
`define BTIO_LINE_DSTARB 4'd9
`define BTIO_LINE_STAR   4'd10
`define BTIO_LINE_DSTARC 4'd11
`define BTIO_MON_BANK    2
`define BTIO_OE_MASK_W   16

// ----------------------------------------------------------------
// Clocking
// ----------------------------------------------------------------
`define BTIO_CLK_HZ      20000000
`define BTIO_REF_HZ      10000000
`define BTIO_REF_HALF    (`BTIO_CLK_HZ / (2 * `BTIO_REF_HZ))
`define BTIO_SW_SETTLE   2'd2

`endif

//--- pkg/btio_pkg.sv
// Types shared by the backplane trigger block.
// Assumes the constants header sits beside it on the include path.
`include "btio_regs.svh"

package btio_pkg;

  // Qualification of a protocol trigger input.
  typedef enum logic [1:0] {POL_HIGH, POL_LOW, POL_RISE, POL_FALL} btio_pol_t;

  // Capture of the clock-select switch after reset.
  typedef enum logic [1:0] {CS_FILL0, CS_FILL1, CS_FILL2, CS_HELD} btio_cs_t;

endpackage

//--- test/btio_monitor.sv
// Port-level checks for the backplane trigger block.
// Assumes binding to btio_top; one clock, synchronous reset.
`include "btio_regs.svh"
module btio_monitor
  import btio_pkg::*;
(
  input wire logic                        clk,
  input wire logic                        reset,
  input wire logic                        clk_src_onboard,
  input wire logic                        clk_src_valid,
  input wire logic [`BTIO_NLINES-1:0]     line_state,
  input wire logic [`BTIO_OE_MASK_W-1:0]  out_en_mask,
  input wire logic [`BTIO_NLINES-1:0]     rise_flag,
  input wire logic [`BTIO_NLINES-1:0]     fall_flag,
  input wire logic [`BTIO_NLINES-1:0]     rise_clr,
  input wire logic                        mon_event,
  input wire logic [1:0][2:0]             trig_src_star,
  input wire btio_pol_t [1:0][2:0]        trig_pol,
  input wire logic [1:0][2:0]             core_trig,
  input wire logic [1:0][2:0]             core_sync,
  input wire logic [1:0][3:0]             sync_map,
  input wire logic [7:0]                  trig_o,
  input wire logic [7:0]                  trig_oe_n,
  input wire logic                        star_oe_n,
  input wire logic                        dstarc_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_float; $fell(reset) |-> &trig_oe_n && star_oe_n; endproperty
  a_float: assert property (p_float)
    else $error("driver on after reset");
  property p_hold;
    clk_src_valid |=> clk_src_valid && $stable(clk_src_onboard);
  endproperty
  a_hold: assert property (p_hold)
    else $error("clock source changed");
  property p_mask;
    out_en_mask[7:0] == ~trig_oe_n && out_en_mask[15:12] == 4'h0
      && out_en_mask[9:8] == 2'h0;
  endproperty
  a_mask: assert property (p_mask)
    else $error("enable mask wrong");
  property p_wave; out_en_mask[11] [*3] |-> dstarc_o != $past(dstarc_o);
  endproperty
  a_wave: assert property (p_wave)
    else $error("reference not toggling");
  property p_off; !out_en_mask[11] [*2] |-> !dstarc_o; endproperty
  a_off: assert property (p_off)
    else $error("reference not stopped");
  property p_stick;
    1'b1 |=> ($past(rise_flag) & ~$past(rise_clr) & ~rise_flag) == 12'h000;
  endproperty
  a_stick: assert property (p_stick)
    else $error("flag lost without clear");
  property p_event; mon_event == (|{rise_flag, fall_flag}); endproperty
  a_event: assert property (p_event)
    else $error("event output wrong");
  property p_cause;
    $rose(rise_flag[0]) |-> $past(line_state[0]) && !$past(line_state[0], 2);
  endproperty
  a_cause: assert property (p_cause)
    else $error("rise flag without rise");
  property p_trig;
    trig_pol[0][0] == POL_HIGH && !trig_src_star[0][0]
      |=> core_trig[0][0] == $past(line_state[0]);
  endproperty
  a_trig: assert property (p_trig)
    else $error("level trigger wrong");
  property p_sync;
    sync_map[0][0] |=> !trig_oe_n[0] && trig_o[0] == $past(core_sync[0][0]);
  endproperty
  a_sync: assert property (p_sync)
    else $error("sync not driven");
  c_wave: cover property (out_en_mask[11] [*3]);
  c_rise: cover property ($rose(rise_flag[0]));
  c_sync: cover property (sync_map[0][0]);
endmodule

bind btio_top btio_monitor i_btio_monitor (.clk, .reset, .clk_src_onboard,
  .clk_src_valid, .line_state, .out_en_mask, .rise_flag, .fall_flag,
  .rise_clr, .mon_event, .trig_src_star, .trig_pol, .core_trig, .core_sync,
  .sync_map, .trig_o, .trig_oe_n, .star_oe_n, .dstarc_o);

//--- test/btio_card.sv
// Model of the other chassis cards sharing the trigger lines.
// Assumes the lines are pulled high when no card drives them.
module btio_card (
  input wire logic [7:0]  trig_o,
  input wire logic [7:0]  trig_oe_n,
  input wire logic        star_o,
  input wire logic        star_oe_n,
  input wire logic [7:0]  ext_en,
  input wire logic [7:0]  ext_val,
  output logic [7:0]      trig_i,
  output logic            star_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // The other card stands off wherever this card drives.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      trig_i[i] = !trig_oe_n[i] ? trig_o[i]
                : (ext_en[i] ? ext_val[i] : 1'b1);
    end
    star_i = star_oe_n ? 1'b1 : star_o;
  end
endmodule

//--- test/btio_top_tb.sv
// Self-checking bench for the backplane trigger block.
// Assumes the partner model and the checker are compiled before it.
module btio_top_tb
  import btio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, clk_src_onboard, clk_src_valid, mon_event, star_i, star_o;
  logic reset = 1'b1, clock_select_switch = 1'b1, a;
  logic star_oe_n, dstarc_o;
  logic [1:0] dio_wr = '0, dio_en = '0, dio_val = '0, dstar_i = '0;
  logic [1:0][5:0] dio_idx = '0;
  logic [11:0] rise_en = '0, fall_en = '0, rise_clr = '0, fall_clr = '0;
  logic [11:0] line_state, rise_flag, fall_flag;
  logic [15:0] out_en_mask;
  logic [1:0][2:0] trig_src_star = '0, core_sync = '0, core_trig;
  btio_pol_t [1:0][2:0] trig_pol = '{default: POL_HIGH};
  logic [1:0][3:0] sync_map = '0;
  logic [7:0] trig_o, trig_oe_n, ext_en = '0, ext_val = '0, trig_i;
  int mismatches, compares, n;
  btio_top i_btio_top (.clk, .reset, .clock_select_switch, .clk_src_onboard,
    .clk_src_valid, .dio_wr, .dio_idx, .dio_en, .dio_val, .line_state,
    .out_en_mask, .rise_en, .fall_en, .rise_clr, .fall_clr, .rise_flag,
    .fall_flag, .mon_event, .trig_src_star, .trig_pol, .core_trig,
    .core_sync, .sync_map, .trig_i, .trig_o, .trig_oe_n, .dstar_i, .star_i,
    .star_o, .star_oe_n, .dstarc_o);
  btio_card i_btio_card (.trig_o, .trig_oe_n, .star_o, .star_oe_n, .ext_en,
    .ext_val, .trig_i, .star_i);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Checks sit on falling edges, so launched updates have landed.
  task automatic tk(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic wr(input int c, input logic [5:0] idx, input logic en, v);
    @(posedge clk);
    dio_wr[c] <= 1'b1;
    dio_idx[c] <= idx;
    dio_en[c] <= en;
    dio_val[c] <= v;
    @(posedge clk);
    dio_wr[c] <= 1'b0;
    @(negedge clk);
  endtask
  task automatic complete_run;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    tk(1);
    @(posedge clk);
    reset <= 1'b0;
    tk(1);
    chk({trig_oe_n, star_oe_n}, 9'h1FF);
    for (int i = 0; i < 10 && clk_src_valid !== 1'b1; i++) tk(1);
    if (clk_src_valid !== 1'b1) mismatches++;
    chk(clk_src_onboard, 1'b1);
    @(posedge clk);
    clock_select_switch <= 1'b0;
    tk(5);
    chk(clk_src_onboard, 1'b1);
    for (int i = 0; i < 8; i++) begin
      wr(0, 6'd33 + 6'(i), 1'b1, i[0]);
      tk(4);
      chk({trig_oe_n[i], trig_o[i], line_state[i]}, {1'b0, i[0], i[0]});
    end
    wr(0, 6'd33, 1'b1, 1'b1);
    wr(1, 6'd33, 1'b1, 1'b0);
    tk(2);
    chk(trig_o[0], 1'b0);
    wr(0, 6'd33, 1'b0, 1'b1);
    wr(1, 6'd33, 1'b0, 1'b1);
    tk(2);
    chk({trig_oe_n[0], out_en_mask[0]}, 2'b10);
    @(posedge clk);
    ext_en <= 8'h01;
    rise_en <= '1;
    fall_en <= '1;
    tk(5);
    @(posedge clk);
    rise_clr <= '1;
    fall_clr <= '1;
    @(posedge clk);
    rise_clr <= '0;
    fall_clr <= '0;
    ext_val <= 8'h01;
    tk(8);
    chk({rise_flag[0], fall_flag[0], mon_event}, 3'b101);
    @(posedge clk);
    rise_clr[0] <= 1'b1;
    @(posedge clk);
    rise_clr[0] <= 1'b0;
    tk(2);
    chk({rise_flag[0], mon_event}, 2'b00);
    for (int p = 0; p < 4; p++) begin
      @(posedge clk);
      trig_pol[0][0] <= btio_pol_t'(p);
      tk(3);
      chk(core_trig[0][0], p == 0);
    end
    @(posedge clk);
    ext_val <= 8'h00;
    n = 0;
    for (int i = 0; i < 8; i++) begin
      tk(1);
      n += core_trig[0][0];
    end
    chk(n[15:0], 16'h0001);
    @(posedge clk);
    trig_src_star[0][1] <= 1'b1;
    dstar_i <= 2'b10;
    tk(5);
    chk({core_trig[0][1], line_state[9:8]}, 3'b110);
    wr(1, 6'd44, 1'b1, 1'b0);
    tk(3);
    a = dstarc_o;
    tk(1);
    chk({out_en_mask[11], dstarc_o}, {1'b1, ~a});
    wr(1, 6'd44, 1'b0, 1'b1);
    tk(2);
    chk({out_en_mask[11], dstarc_o}, 2'b00);
    @(posedge clk);
    sync_map[0] <= 4'hD;
    core_sync[0] <= 3'b101;
    tk(3);
    chk({trig_o[0], trig_oe_n[0], trig_o[2], trig_oe_n[2], star_o,
         star_oe_n, out_en_mask[10]}, 7'h55);
    // A second reset with the switch now low captures the new source.
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 10 && clk_src_valid !== 1'b1; i++) tk(1);
    if (clk_src_valid !== 1'b1) mismatches++;
    chk(clk_src_onboard, 1'b0);
    chk(rise_flag | fall_flag, 12'h000);
    complete_run();
  end
endmodule
